// file: verilog/timer_consts.svh
// Register offsets, field positions, reset values and counter limits of the timer core
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// Byte offsets on the register bus
`define OFS_TIMER_CONTROL 8'h00
`define OFS_TIMER_COUNTER 8'h04
`define OFS_TIMER_PERIOD 8'h08
`define OFS_TIMER_COMPARE 8'h0C
`define OFS_GLOBAL_CONTROL 8'h10
`define OFS_EVENT_FLAGS 8'h14

// Timer control register fields
`define CTL_CMP_EN_BIT 1
`define CTL_CLKSRC_LSB 4
`define CTL_ENABLE_BIT 6
`define CTL_PRESC_LSB 8
`define CTL_MODE_LSB 11
`define CTL_SOFT_BIT 14
`define CTL_FREE_BIT 15

// Global control register fields
`define GTC_ADC_SEL_LSB 7
`define GTC_DIR_BIT 13

// Event flag register fields
`define EVF_PERIOD_BIT 0
`define EVF_COMPARE_BIT 1
`define EVF_UNDERFLOW_BIT 2
`define EVF_OVERFLOW_BIT 3

// Reset values
`define RST_CONTROL 16'h0000
`define RST_COUNTER 16'h0000
`define RST_PERIOD 16'h0000
`define RST_COMPARE 16'h0000
`define RST_ADC_SEL 2'h0

// Counter limits
`define CNT_TOP 16'hFFFF
`define CNT_ZERO 16'h0000

`endif

// file: verilog/timer_pkg.sv
// Types shared by the timer core modules
package timer_pkg;

  // Counting modes; codes above 3'b010 are the up/down modes, held like stop here
  typedef enum logic [2:0] {
    MODE_STOP = 3'b000,
    MODE_SINGLE_UP = 3'b001,
    MODE_CONT_UP = 3'b010,
    MODE_DIR_UPDOWN = 3'b011,
    MODE_SINGLE_UPDOWN = 3'b100,
    MODE_CONT_UPDOWN = 3'b101
  } count_mode_t;

  // Event that starts an ADC conversion
  typedef enum logic [1:0] {
    ADC_NONE = 2'b00,
    ADC_ON_UNDERFLOW = 2'b01,
    ADC_ON_PERIOD = 2'b10,
    ADC_ON_COMPARE = 2'b11
  } adc_sel_t;

endpackage

// file: verilog/prescale_if.sv
// Signals between the timer core and its prescaler
`timescale 1ns/100ps
`default_nettype none
interface prescale_if;
  logic clear;
  logic hold;
  logic use_ext;
  logic ext_pulse;
  logic [2:0] div_code;
  logic tick;

  modport core (output clear, output hold, output use_ext, output ext_pulse,
                output div_code, input tick);
  modport presc (input clear, input hold, input use_ext, input ext_pulse,
                 input div_code, output tick);
endinterface
`default_nettype wire

// file: verilog/timer_prescaler.sv
// Clock source select and divide-by-2^n prescaler producing scaled count ticks
`timescale 1ns/100ps
`default_nettype none
module timer_prescaler
  import timer_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Core side
  prescale_if.presc pif
);

  logic [6:0] div_cnt_reg;
  logic src_pulse;
  logic at_wrap;

  function automatic logic [6:0] div_mask(input logic [2:0] code);
    div_mask = 7'(({7'h00, 1'b1} << code) - 8'h01);
  endfunction

  // Internal source gives one pulse per CPU clock
  assign src_pulse = pif.use_ext ? pif.ext_pulse : 1'b1;
  // At or past the mask: a smaller code picked while a count is held wraps at once
  assign at_wrap = (div_cnt_reg >= div_mask(pif.div_code));
  assign pif.tick = !pif.clear && !pif.hold && src_pulse && at_wrap;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_reg <= 7'h00;
    end else if (pif.clear) begin
      div_cnt_reg <= 7'h00;
    end else if (!pif.hold && src_pulse) begin
      div_cnt_reg <= at_wrap ? 7'h00 : 7'(div_cnt_reg + 7'h01);
    end
  end

endmodule
`default_nettype wire

// file: verilog/timer_core_top.sv
// Up-counting timer core with Wishbone registers, event flags and ADC start
//
// Overview of operation
// - Selected timer event pulses ADC start
// - Emulation suspend: run, stop now, stop at period end
// - Four event flags per timer
// - Compare flag set two cycles after match
// - Overflow at FFFFh, underflow at 0000h
// - Period event; flags two cycles after event
// - Mode field: stop, single up, continuous up
// - Enable clear stops counting, resets prescaler
// - Prescale field divides input clock, 001 halves
// - Stop/hold freezes counter and prescaler
// - Single up: clear count and enable after match
// - Period ADC start with period flag
// - Underflow ADC start with underflow flag
// - Zero start: period lasts period plus one
// - Start above period wraps through FFFFh
// - Start at period: period then underflow
// - Direction bit reads one in up modes, zero otherwise, direction pin unused
// - Counting starts immediately on enable
// - Continuous up restarts without lost clock
// - Later continuous periods last period plus one
// - Internal or external clock source selectable
//
// The register addresses and the Wishbone register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "timer_consts.svh"
module timer_core_top
  import timer_pkg::*;
(
  // System
  input wire logic CLK_I,
  input wire logic RST_I,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // Pins
  input wire logic EXT_TIMER_CLOCK_I,
  input wire logic EMU_SUSPEND_I,
  // Event outputs
  output logic ADC_START_O,
  output logic OVERFLOW_IRQ_O,
  output logic UNDERFLOW_IRQ_O,
  output logic COMPARE_IRQ_O,
  output logic PERIOD_IRQ_O
);

  prescale_if pif ();

  // Pin synchronisers
  logic [2:0] ext_sync_reg;
  logic ext_level_reg;
  logic ext_level_prev_reg;
  logic [2:0] susp_sync_reg;
  logic susp_level_reg;

  // Bus
  logic wb_req;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] rd_data;
  logic wr_stb;

  // Registers
  logic [15:0] timer_control_reg;
  logic [15:0] timer_counter_reg;
  logic [15:0] timer_period_reg;
  logic [15:0] timer1_compare_value;
  adc_sel_t adc_sel_reg;
  logic [3:0] event_flag_reg_a;
  logic [3:0] event_flag_next;

  // Counting control
  count_mode_t mode;
  logic enable;
  logic up_mode;
  logic free_run;
  logic soft_stop;
  logic halt;
  logic run;
  logic tick_adv;
  logic at_period;
  logic enable_prev_reg;
  logic susp_end_reg;

  // Event pipeline
  logic arm_step_reg;
  logic arm_start;
  logic [3:0] ev_now;
  logic [3:0] ev_d1_reg;
  logic [3:0] flag_clr;
  logic adc_start_reg;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic wr_to(input logic wr, input logic [7:0] adr, input logic [7:0] ofs);
    wr_to = wr && (adr[7:2] == ofs[7:2]);
  endfunction

  // External clock: three flops, a change counts when the last two agree
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ext_sync_reg <= 3'h0;
      ext_level_reg <= 1'b0;
      ext_level_prev_reg <= 1'b0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], EXT_TIMER_CLOCK_I};
      if (ext_sync_reg[1] == ext_sync_reg[2]) begin
        ext_level_reg <= ext_sync_reg[2];
      end
      ext_level_prev_reg <= ext_level_reg;
    end
  end

  // Emulation suspend pin, same filtering
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      susp_sync_reg <= 3'h0;
      susp_level_reg <= 1'b0;
    end else begin
      susp_sync_reg <= {susp_sync_reg[1:0], EMU_SUSPEND_I};
      if (susp_sync_reg[1] == susp_sync_reg[2]) begin
        susp_level_reg <= susp_sync_reg[2];
      end
    end
  end

  // Field decode
  // Mode codes above continuous up are held like stop/hold
  assign mode = count_mode_t'(timer_control_reg[`CTL_MODE_LSB +: 3]);
  assign enable = timer_control_reg[`CTL_ENABLE_BIT];
  assign free_run = timer_control_reg[`CTL_FREE_BIT];
  assign soft_stop = timer_control_reg[`CTL_SOFT_BIT];
  assign up_mode = (mode == MODE_SINGLE_UP) || (mode == MODE_CONT_UP);
  assign at_period = (timer_counter_reg == timer_period_reg);

  // Suspend stops at once, or only once the current period has ended
  // The pin is filtered, so suspend acts a few cycles after it rises
  assign halt = susp_level_reg && !free_run && (!soft_stop || susp_end_reg);
  assign run = enable && up_mode && !halt;
  assign tick_adv = run && pif.tick;

  // Prescaler hookup; a held prescaler keeps its count
  assign pif.clear = !enable;
  assign pif.hold = !run;
  assign pif.use_ext = (timer_control_reg[`CTL_CLKSRC_LSB +: 2] == 2'b01);
  assign pif.ext_pulse = ext_level_reg && !ext_level_prev_reg;
  assign pif.div_code = timer_control_reg[`CTL_PRESC_LSB +: 3];

  timer_prescaler i_timer_prescaler (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .pif(pif)
  );

  // Wishbone: ack one cycle after the request, write lands on the ack edge
  // Unmapped offsets read zero, drop writes and are still acknowledged
  assign wb_req = CYC_I && STB_I;
  assign wr_stb = wb_req && ack_reg && WE_I;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req && !ack_reg;
    end
  end

  always_comb begin
    rd_data = 32'h00000000;
    unique case (ADR_I[7:2])
      6'(`OFS_TIMER_CONTROL >> 2): rd_data[15:0] = timer_control_reg;
      6'(`OFS_TIMER_COUNTER >> 2): rd_data[15:0] = timer_counter_reg;
      6'(`OFS_TIMER_PERIOD >> 2): rd_data[15:0] = timer_period_reg;
      6'(`OFS_TIMER_COMPARE >> 2): rd_data[15:0] = timer1_compare_value;
      6'(`OFS_GLOBAL_CONTROL >> 2): begin
        rd_data[`GTC_ADC_SEL_LSB +: 2] = adc_sel_reg;
        rd_data[`GTC_DIR_BIT] = up_mode;
      end
      6'(`OFS_EVENT_FLAGS >> 2): rd_data[3:0] = event_flag_reg_a;
      default: rd_data = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      dat_reg <= 32'h00000000;
    end else if (wb_req && !ack_reg) begin
      dat_reg <= rd_data;
    end
  end

  // Control register; a software write wins over the end-of-run clear
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      timer_control_reg <= `RST_CONTROL;
    end else if (wr_to(wr_stb, ADR_I, `OFS_TIMER_CONTROL)) begin
      timer_control_reg <= merge16(timer_control_reg, DAT_I, SEL_I);
    end else if (tick_adv && at_period && mode == MODE_SINGLE_UP) begin
      timer_control_reg[`CTL_ENABLE_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      timer_period_reg <= `RST_PERIOD;
    end else if (wr_to(wr_stb, ADR_I, `OFS_TIMER_PERIOD)) begin
      timer_period_reg <= merge16(timer_period_reg, DAT_I, SEL_I);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      timer1_compare_value <= `RST_COMPARE;
    end else if (wr_to(wr_stb, ADR_I, `OFS_TIMER_COMPARE)) begin
      timer1_compare_value <= merge16(timer1_compare_value, DAT_I, SEL_I);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      adc_sel_reg <= adc_sel_t'(`RST_ADC_SEL);
    end else if (wr_to(wr_stb, ADR_I, `OFS_GLOBAL_CONTROL) && SEL_I[0] && SEL_I[1]) begin
      adc_sel_reg <= adc_sel_t'(DAT_I[`GTC_ADC_SEL_LSB +: 2]);
    end
  end

  // Counter: period match clears to zero on the same tick that would count
  // A counter write in a tick cycle wins and that tick is dropped
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      timer_counter_reg <= `RST_COUNTER;
    end else if (wr_to(wr_stb, ADR_I, `OFS_TIMER_COUNTER)) begin
      timer_counter_reg <= merge16(timer_counter_reg, DAT_I, SEL_I);
    end else if (tick_adv) begin
      if (at_period) begin
        timer_counter_reg <= `CNT_ZERO;
      end else begin
        timer_counter_reg <= 16'(timer_counter_reg + 16'h0001);
      end
    end
  end

  // Soft suspend: remember that a period ended while suspended
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      susp_end_reg <= 1'b0;
    end else if (!susp_level_reg) begin
      susp_end_reg <= 1'b0;
    end else if (tick_adv && at_period) begin
      susp_end_reg <= 1'b1;
    end
  end

  // Start marker is combinational so it flags the cycle that shows the starting value
  assign arm_start = enable && !enable_prev_reg && up_mode;

  // Last cycle's enable, to spot a software start
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      enable_prev_reg <= 1'b0;
    end else begin
      enable_prev_reg <= enable;
    end
  end

  // A step marks the cycle in which the counter shows a freshly reached value
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      arm_step_reg <= 1'b0;
    end else begin
      arm_step_reg <= tick_adv;
    end
  end

  // Starting value only raises period and compare; zero and top need a step
  always_comb begin
    ev_now = 4'h0;
    ev_now[`EVF_PERIOD_BIT] = (arm_step_reg || arm_start) && at_period;
    ev_now[`EVF_COMPARE_BIT] = (arm_step_reg || arm_start) &&
                               timer_control_reg[`CTL_CMP_EN_BIT] &&
                               (timer_counter_reg == timer1_compare_value);
    ev_now[`EVF_UNDERFLOW_BIT] = arm_step_reg && (timer_counter_reg == `CNT_ZERO);
    ev_now[`EVF_OVERFLOW_BIT] = arm_step_reg && (timer_counter_reg == `CNT_TOP);
  end

  // One stage here and the flag flop give the two-cycle latency
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ev_d1_reg <= 4'h0;
    end else begin
      ev_d1_reg <= ev_now;
    end
  end

  // Write one to clear; a new event in the clearing cycle still sets
  assign flag_clr = (wr_to(wr_stb, ADR_I, `OFS_EVENT_FLAGS) && SEL_I[0]) ? DAT_I[3:0] : 4'h0;
  assign event_flag_next = (event_flag_reg_a & ~flag_clr) | ev_d1_reg;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      event_flag_reg_a <= 4'h0;
    end else begin
      event_flag_reg_a <= event_flag_next;
    end
  end

  // ADC start pulses in the cycle the matching flag is set
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      adc_start_reg <= 1'b0;
    end else begin
      unique case (adc_sel_reg)
        ADC_NONE: adc_start_reg <= 1'b0;
        ADC_ON_UNDERFLOW: adc_start_reg <= ev_d1_reg[`EVF_UNDERFLOW_BIT];
        ADC_ON_PERIOD: adc_start_reg <= ev_d1_reg[`EVF_PERIOD_BIT];
        ADC_ON_COMPARE: adc_start_reg <= ev_d1_reg[`EVF_COMPARE_BIT];
      endcase
    end
  end

  // Outputs, all from flops
  assign DAT_O = dat_reg;
  assign ACK_O = ack_reg;
  assign ADC_START_O = adc_start_reg;
  assign PERIOD_IRQ_O = event_flag_reg_a[`EVF_PERIOD_BIT];
  assign COMPARE_IRQ_O = event_flag_reg_a[`EVF_COMPARE_BIT];
  assign UNDERFLOW_IRQ_O = event_flag_reg_a[`EVF_UNDERFLOW_BIT];
  assign OVERFLOW_IRQ_O = event_flag_reg_a[`EVF_OVERFLOW_BIT];

endmodule
`default_nettype wire

// file: sim/adc_model.sv
// Converter stand-in that counts start pulses from the timer
`timescale 1ns/100ps
`default_nettype none
module adc_model (
  // Clock
  input wire logic clk_i,
  // Start request from the timer
  input wire logic start_i,
  output logic [7:0] starts_o
);
  initial starts_o = 8'h00;
  // One conversion per high cycle, so a stretched pulse shows as extra starts
  always @(posedge clk_i) begin
    if (start_i) starts_o <= starts_o + 8'h01;
  end
endmodule
`default_nettype wire

// file: sim/timer_core_sva.sv
// Port checks of the timer core
`timescale 1ns/100ps
`default_nettype none
module timer_core_sva (
  // System
  input wire logic CLK_I,
  input wire logic RST_I,
  // Wishbone
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  // Events
  input wire logic ADC_START_O,
  input wire logic OVERFLOW_IRQ_O,
  input wire logic UNDERFLOW_IRQ_O,
  input wire logic COMPARE_IRQ_O,
  input wire logic PERIOD_IRQ_O
);
  logic clr;
  // Loose on purpose: any landing flag write may drop a flag
  assign clr = ACK_O && WE_I && ADR_I[7:2] == 6'h05 && SEL_I[0];
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_ack_follows_req: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (ACK_O |-> $past(CYC_I && STB_I))
    else $error("ack without request");
  a_read_upper_zero: assert property (ACK_O |-> DAT_O[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_adc_with_flag: assert property (ADC_START_O |-> ##0 (UNDERFLOW_IRQ_O || PERIOD_IRQ_O || COMPARE_IRQ_O))
    else $error("adc start without event flag");
  a_period_sticky: assert property (PERIOD_IRQ_O && !clr |=> PERIOD_IRQ_O)
    else $error("period flag dropped");
  a_under_sticky: assert property (UNDERFLOW_IRQ_O && !clr |=> UNDERFLOW_IRQ_O)
    else $error("underflow flag dropped");
  a_over_sticky: assert property (OVERFLOW_IRQ_O && !clr |=> OVERFLOW_IRQ_O)
    else $error("overflow flag dropped");
  a_compare_sticky: assert property (COMPARE_IRQ_O && !clr |=> COMPARE_IRQ_O)
    else $error("compare flag dropped");
endmodule
bind timer_core_top timer_core_sva i_timer_core_sva (.CLK_I(CLK_I), .RST_I(RST_I),
  .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I),
  .DAT_O(DAT_O), .ACK_O(ACK_O), .ADC_START_O(ADC_START_O),
  .OVERFLOW_IRQ_O(OVERFLOW_IRQ_O), .UNDERFLOW_IRQ_O(UNDERFLOW_IRQ_O),
  .COMPARE_IRQ_O(COMPARE_IRQ_O), .PERIOD_IRQ_O(PERIOD_IRQ_O));
`default_nettype wire

// file: sim/timer_core_top_tb.sv
// Self-checking bench of the timer core
`timescale 1ns/100ps
`default_nettype none
module timer_core_top_tb
  import timer_pkg::*;
;
  logic CLK_I = 1'b0, RST_I = 1'b1, CYC_I = 1'b0, STB_I = 1'b0, WE_I = 1'b0;
  logic EXT_TIMER_CLOCK_I = 1'b0, EMU_SUSPEND_I = 1'b0;
  logic [7:0] ADR_I = 8'h00;
  logic [3:0] SEL_I = 4'h0;
  logic [31:0] DAT_I = 32'h0, DAT_O;
  logic ACK_O, ADC_START_O, OVERFLOW_IRQ_O, UNDERFLOW_IRQ_O, COMPARE_IRQ_O, PERIOD_IRQ_O;
  logic [7:0] starts;
  int errors = 0, cmp_count = 0, cyc = 0;
  int t_single[4] = '{0, 6, 5, 4};
  timer_core_top i_timer_core_top (.CLK_I(CLK_I), .RST_I(RST_I), .CYC_I(CYC_I),
    .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I),
    .DAT_O(DAT_O), .ACK_O(ACK_O), .EXT_TIMER_CLOCK_I(EXT_TIMER_CLOCK_I),
    .EMU_SUSPEND_I(EMU_SUSPEND_I), .ADC_START_O(ADC_START_O),
    .OVERFLOW_IRQ_O(OVERFLOW_IRQ_O), .UNDERFLOW_IRQ_O(UNDERFLOW_IRQ_O),
    .COMPARE_IRQ_O(COMPARE_IRQ_O), .PERIOD_IRQ_O(PERIOD_IRQ_O));
  adc_model i_adc_model (.clk_i(CLK_I), .start_i(ADC_START_O), .starts_o(starts));
  always #50 CLK_I = ~CLK_I;
  task automatic finish_test;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd,
                    input logic [3:0] s, output logic [31:0] rd);
    int w;
    @(posedge CLK_I);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    ADR_I <= a;
    DAT_I <= wd;
    SEL_I <= s;
    w = 0;
    do begin
      @(posedge CLK_I);
      w++;
    end while (ACK_O !== 1'b1 && w < 20);
    if (ACK_O !== 1'b1) errors++;
    rd = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] x;
    wb(1'b1, a, {16'h0000, d}, 4'h3, x);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [15:0] e);
    logic [31:0] x;
    wb(1'b0, a, 32'h0, 4'h3, x);
    chk(nm, {16'h0000, e}, x);
  endtask
  // Two counter reads exactly eight clock edges apart
  task automatic samp(output logic [31:0] a, output logic [31:0] b);
    wb(1'b0, 8'h04, 32'h0, 4'h3, a);
    repeat (5) @(posedge CLK_I);
    wb(1'b0, 8'h04, 32'h0, 4'h3, b);
  endtask
  task automatic reset_chk;
    for (int i = 0; i < 9; i++) begin
      rd("reset", 8'(i * 4), 16'h0000);
    end
    wr(8'h20, 16'h1234);
    rd("unmapped", 8'h20, 16'h0000);
  endtask
  // Flags must rise at cycle t after enable and then stay; t of 99 means never
  task automatic run_chk(input string nm, input logic [15:0] ctl, input logic [15:0] cnt,
      input logic [15:0] per, input adc_sel_t sel, input int t_ov, input int t_un,
      input int t_pe, input int t_cm, input int t_adc);
    logic [7:0] s0;
    wr(8'h10, 16'(sel) << 7);
    wr(8'h14, 16'h000F);
    wr(8'h08, per);
    wr(8'h0C, 16'h0001);
    wr(8'h04, cnt);
    s0 = starts;
    wr(8'h00, ctl);
    for (int n = 1; n < 10; n++) begin
      @(negedge CLK_I);
      chk(nm, {n >= t_ov, n >= t_un, n >= t_pe, n >= t_cm}, {OVERFLOW_IRQ_O,
          UNDERFLOW_IRQ_O, PERIOD_IRQ_O, COMPARE_IRQ_O});
      chk(nm, n == t_adc, ADC_START_O);
    end
    chk(nm, {7'h00, t_adc != 0}, starts - s0);
    rd(nm, 8'h00, ctl & 16'hFFBF);
    rd(nm, 8'h04, 16'h0000);
    rd(nm, 8'h10, 16'h2000 | (16'(sel) << 7));
  endtask
  task automatic cont_chk;
    logic [31:0] a, b;
    int last;
    wr(8'h10, 16'(ADC_ON_PERIOD) << 7);
    wr(8'h08, 16'h0003);
    wr(8'h04, 16'h0000);
    wr(8'h00, 16'h1040);
    last = 2;
    for (int n = 1; n < 20; n++) begin
      @(negedge CLK_I);
      if (ADC_START_O === 1'b1) begin
        chk("cont gap", last + 4, n);
        last = n;
      end
    end
    chk("cont last", 18, last);
    wr(8'h08, 16'hFFFF);
    samp(a, b);
    chk("div1", 8, b - a);
    wr(8'h00, 16'h1140);
    samp(a, b);
    chk("div2", 4, b - a);
    wr(8'h00, 16'h0140);
    samp(a, b);
    chk("hold", 0, b - a);
    EMU_SUSPEND_I <= 1'b1;
    wr(8'h00, 16'h9040);
    samp(a, b);
    chk("free", 8, b - a);
    wr(8'h00, 16'h5040);
    samp(a, b);
    chk("soft", 8, b - a);
    wr(8'h00, 16'h1040);
    samp(a, b);
    chk("stop", 0, b - a);
    EMU_SUSPEND_I <= 1'b0;
    wr(8'h00, 16'h0000);
    samp(a, b);
    chk("off", 0, b - a);
  endtask
  task automatic ext_chk;
    wr(8'h04, 16'h0000);
    wr(8'h00, 16'h1050);
    repeat (3) begin
      repeat (4) @(posedge CLK_I);
      EXT_TIMER_CLOCK_I <= 1'b1;
      repeat (4) @(posedge CLK_I);
      EXT_TIMER_CLOCK_I <= 1'b0;
    end
    repeat (8) @(posedge CLK_I);
    wr(8'h00, 16'h0000);
    rd("ext count", 8'h04, 16'h0003);
  endtask
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      finish_test;
    end
  end
  initial begin
    repeat (4) @(posedge CLK_I);
    RST_I <= 1'b0;
    reset_chk;
    for (int i = 0; i < 4; i++) begin
      run_chk("single", 16'h0842, 16'h0000, 16'h0002, adc_sel_t'(i), 99, 6, 5, 4,
              t_single[i]);
    end
    run_chk("wrap", 16'h0840, 16'hFFFE, 16'h0003, ADC_ON_PERIOD, 4, 5, 8, 99, 8);
    run_chk("at period", 16'h0840, 16'h0002, 16'h0002, ADC_ON_UNDERFLOW, 99, 4, 3, 99,
            4);
    cont_chk;
    ext_chk;
    finish_test;
  end
endmodule
`default_nettype wire
